// [testbench/kms_asserts.sv]
// checker on the scanner's pins, irqs and bus responses
// bound to kms_top; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module kms_asserts #(parameter int ROWS = 18)
  (
  // watched ports
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [ROWS-1:0] row_drive_outputs,
  input wire logic [ROWS-1:0] row_drive_oe_n,
  input wire logic bus_clk_stopped,
  input wire logic scan_runtime_irq,
  input wire logic scan_wake_irq,
  input wire logic scan_sleep_block
  );
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset checks have to run while reset is held
  property p_rst_irq; disable iff (1'b0)
    !aresetn |=> !scan_runtime_irq && !scan_wake_irq; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq in reset");
  property p_rst_row; disable iff (1'b0)
    !aresetn |=> &row_drive_oe_n && !scan_sleep_block; endproperty
  a_rst_row: assert property (p_rst_row) else $error("row in reset");
  property p_rst_rsp; disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_rst_rsp: assert property (p_rst_rsp) else $error("resp in reset");
  property p_rel; &(row_drive_outputs | ~row_drive_oe_n); endproperty
  a_rel: assert property (p_rel) else $error("released row low");
  property p_slo; (&row_drive_oe_n) [*3] |-> !scan_sleep_block; endproperty
  a_slo: assert property (p_slo) else $error("idle blocks sleep");
  property p_shi; !(&row_drive_oe_n) |-> scan_sleep_block; endproperty
  a_shi: assert property (p_shi) else $error("active lets sleep");
  property p_wclr; !bus_clk_stopped [*5] |-> !scan_wake_irq; endproperty
  a_wclr: assert property (p_wclr) else $error("wake with clock");
  property p_wset; $rose(scan_wake_irq) |-> $past(bus_clk_stopped, 3);
  endproperty
  a_wset: assert property (p_wset) else $error("wake not stopped");
endmodule
bind kms_top kms_asserts #(.ROWS(ROWS)) u_chk (.*);
`default_nettype wire

// [testbench/kms_matrix.sv]
// one-key switch matrix with pull-ups on rows and columns
// assumes one closed key at key_row/key_col while key_on
`timescale 1ns/10ps
`default_nettype none
module kms_matrix
  (
  // row pins in, the key, column pins out
  input wire logic [17:0] rows,
  input wire logic [17:0] rows_oe_n,
  input wire logic key_on,
  input wire logic [4:0] key_row,
  input wire logic [2:0] key_col,
  output logic [7:0] cols
  );
  logic [17:0] lvl;
  // released rows float up, so only a row driven low can pull a column
  assign lvl = rows | rows_oe_n;
  assign cols = key_on && !lvl[key_row] ? ~(8'h01 << key_col) : 8'hFF;
endmodule
`default_nettype wire

// [testbench/tb_keyboard_matrix_scanner.sv]
// bench for kms_top: axi4-lite registers, one key, irqs, predrive
// assumes kms_matrix and the bound checker are compiled with it
`timescale 1ns/10ps
`default_nettype none
module tb_keyboard_matrix_scanner;
  logic aclk = 0, aresetn = 0, bus_clk_stopped = 0, key_on = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  // response readies stay high: legal, and never a double assignment
  logic s_axi_bready = 1, s_axi_rready = 1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, column_sense_inputs;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, scan_runtime_irq, scan_wake_irq, scan_sleep_block;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [17:0] row_drive_outputs, row_drive_oe_n;
  logic [4:0] key_row = 5'h05;
  logic [2:0] key_col = 3'h3;
  int n_fail = 0, comparisons = 0;
  always #2 aclk = ~aclk;
  kms_top dut (.*);
  kms_matrix u_keys (.rows(row_drive_outputs), .rows_oe_n(row_drive_oe_n),
    .key_on, .key_row, .key_col, .cols(column_sense_inputs));
  // irq, wake, sleep block and row enables packed for one compare
  function automatic logic [31:0] st();
    return 32'({scan_runtime_irq, scan_wake_irq, scan_sleep_block,
      row_drive_oe_n});
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tk(input int n); repeat (n) @(posedge aclk); endtask
  task automatic ck(input int n, input logic [31:0] e);
    tk(n);
    chk(st(), e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), a == 8'h00 ? 32'h2 : 32'h0);
  endtask
  // response code lands in the top bits, which a register never uses
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata[29:0]}, exp);
  endtask
  task automatic t_scan();
    int rs[3] = '{0, 5, 17};
    chk(st(), 32'h0003_FFFF);
    rchk(8'h04, 32'h0000_0040);
    rchk(8'h00, 32'h8000_0000);
    wr(8'h00, 32'h0000_00FF);
    key_on <= 1'b1;
    foreach (rs[i])
    begin
      wr(8'h04, 32'(rs[i]));
      ck(1, 32'h0007_FFFF ^ (32'h1 << rs[i]));
      chk(32'(row_drive_outputs), 32'h0003_FFFF ^ (32'h1 << rs[i]));
      tk(4);
      rchk(8'h08, rs[i] == 5 ? 32'h0000_00F7 : 32'h0000_00FF);
    end
    wr(8'h04, 32'h0000_0020);
    ck(1, 32'h0004_0000);
    chk(32'(row_drive_outputs), 32'h0000_0000);
    wr(8'h04, 32'h0000_0012);
    ck(1, 32'h0004_0000);
    chk(32'(row_drive_outputs), 32'h0003_FFFF);
    rchk(8'h18, 32'h0000_0001);
    wr(8'h04, 32'h0000_0040);
    ck(4, 32'h0003_FFFF);
  endtask
  task automatic t_irq();
    key_on <= 1'b0;
    wr(8'h04, 32'h0000_0005);
    wr(8'h0C, 32'h0000_00FF);
    wr(8'h10, 32'h0000_0008);
    key_on <= 1'b1;
    ck(8, 32'h0017_FFDF);
    wr(8'h0C, 32'h0000_0008);
    ck(2, 32'h0007_FFDF);
    key_on <= 1'b0;
    key_col <= 3'h4;
    tk(4);
    key_on <= 1'b1;
    ck(8, 32'h0007_FFDF);
    rchk(8'h0C, 32'h0000_0010);
    key_on <= 1'b0;
    key_col <= 3'h3;
    wr(8'h0C, 32'h0000_00FF);
  endtask
  task automatic t_wake();
    bus_clk_stopped <= 1'b1;
    tk(4);
    key_on <= 1'b1;
    tk(8);
    chk(32'(scan_wake_irq), 32'h1);
    key_on <= 1'b0;
    tk(8);
    chk(32'(scan_wake_irq), 32'h1);
    bus_clk_stopped <= 1'b0;
    ck(8, 32'h0017_FFDF);
    wr(8'h0C, 32'h0000_00FF);
  endtask
  task automatic t_pre();
    wr(8'h04, 32'h0000_0040);
    wr(8'h14, 32'h0000_0001);
    wr(8'h04, 32'h0000_0002);
    wr(8'h04, 32'h0000_0042);
    ck(1, 32'h0007_FFFB);
    chk(32'({row_drive_oe_n[2], row_drive_outputs[2]}), 32'h1);
    tk(9);
    chk(32'({row_drive_oe_n[2], row_drive_outputs[2]}), 32'h1);
    tk(2);
    chk(32'({row_drive_oe_n[2], row_drive_outputs[2]}), 32'h3);
    ck(16, 32'h0003_FFFF);
  endtask
  task automatic t_rst();
    wr(8'h10, 32'h0000_00FF);
    wr(8'h04, 32'h0000_0000);
    aresetn <= 1'b0;
    tk(3);
    aresetn <= 1'b1;
    tk(3);
    chk(st(), 32'h0003_FFFF);
    rchk(8'h04, 32'h0000_0040);
    rchk(8'h10, 32'h0000_0000);
    rchk(8'h14, 32'h0000_0000);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    tk(20000);
    n_fail++;
    complete_run();
  end
  initial
  begin
    tk(20);
    aresetn <= 1'b1;
    tk(3);
    t_scan();
    t_irq();
    t_wake();
    t_pre();
    t_rst();
    complete_run();
  end
endmodule
`default_nettype wire

// [verilog/kms_pkg.sv]
// constants, register map and timing for the keyboard matrix scanner
// assumes a single 250 MHz clock domain and an axi4-lite register port
//
// Notes on behaviour
// - up to eighteen row outputs and eight column inputs are supported
// - all scan logic runs on the one scan clock
// - active-low reset returns every register and internal state to default
// - two interrupt outputs: runtime request and separate wake request
// - scanner enters low power by itself whenever it is not scanning
// - scanner is also in low power while scan_off is set
// - low power never blocks chip sleep; active scanning holds sleep off
// - firmware drives one row low, reads columns; pressed key reads zero
// - in predrive a row is driven high briefly before going open-drain
// - predrive is switched by an enable bit in extended control
// - each column has a falling-edge status bit; enabled ones raise irq
// - falling enabled column with bus clock stopped holds wake until restart
package kms_pkg;
  localparam int KMS_ROWS = 18;
  localparam int KMS_COLS = 8;
  localparam logic [7:0] KMS_OFS_ROWSEL = 8'h04;
  localparam logic [7:0] KMS_OFS_COLIN = 8'h08;
  localparam logic [7:0] KMS_OFS_STS = 8'h0C;
  localparam logic [7:0] KMS_OFS_IEN = 8'h10;
  localparam logic [7:0] KMS_OFS_EXT = 8'h14;
  localparam logic [7:0] KMS_OFS_PWR = 8'h18;
  // row select and extended control register fields
  localparam int KMS_SEL_LSB = 0;
  localparam int KMS_SEL_W = 5;
  localparam int KMS_ALL_BIT = 5;
  localparam int KMS_OFF_BIT = 6;
  localparam int KMS_INV_BIT = 7;
  localparam logic [7:0] KMS_ROWSEL_RST = 8'h40;
  localparam int KMS_PRE_BIT = 0;
  // power register fields
  localparam int KMS_ACT_BIT = 0;
  localparam int KMS_BUSSTOP_BIT = 1;
  // predrive high time
  localparam int KMS_CLK_MHZ = 250;
  localparam int KMS_PRE_NS = 40;
  localparam int KMS_PRE_CYC = (KMS_PRE_NS * KMS_CLK_MHZ + 999) / 1000;
  localparam logic [1:0] KMS_OKAY = 2'b00;
  localparam logic [1:0] KMS_SLVERR = 2'b10;
endpackage

// [verilog/kms_top.sv]
// keyboard matrix scanner: row drive, column sense, interrupts, axi4-lite
// assumes column pins are asynchronous and rows have pull-ups
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module kms_top
  #(parameter int ROWS = kms_pkg::KMS_ROWS,
    parameter int COLS = kms_pkg::KMS_COLS)
  (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // matrix pins
  output logic [ROWS-1:0] row_drive_outputs,
  output logic [ROWS-1:0] row_drive_oe_n,
  input wire logic [COLS-1:0] column_sense_inputs,
  // system side
  input wire logic bus_clk_stopped,
  output logic scan_runtime_irq,
  output logic scan_wake_irq,
  output logic scan_sleep_block
  );
  import kms_pkg::*;

  typedef enum logic [1:0] {KMS_IDLE, KMS_PRE, KMS_HOLD} kms_row_t;

  logic [7:0] rowsel_q;
  logic pre_en_q;
  logic [COLS-1:0] ien_q, sts_q, col_s1_q, col_s2_q, col_prev_q;
  logic [COLS-1:0] fall;
  logic stop_s1_q, stop_s2_q;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q;
  logic [ROWS-1:0] act_d, act_q;
  logic [ROWS-1:0] lvl_d;
  logic [7:0] pre_cnt_q;
  kms_row_t st_q;
  logic wr_go, rd_go;
  logic [31:0] rd_d;
  logic rd_ok;
  logic wr_ok;

  // two-stage synchronisers for column pins and bus-clock status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      col_s1_q <= '1;
      col_s2_q <= '1;
      col_prev_q <= '1;
      stop_s1_q <= 1'b0;
      stop_s2_q <= 1'b0;
    end
    else
    begin
      col_s1_q <= column_sense_inputs;
      col_s2_q <= col_s1_q;
      col_prev_q <= col_s2_q;
      stop_s1_q <= bus_clk_stopped;
      stop_s2_q <= stop_s1_q;
    end
  end

  assign fall = col_prev_q & ~col_s2_q;

  // row drive decode; sel > 17 means all rows with inverted sense
  always_comb
  begin
    act_d = '0;
    lvl_d = '1;
    if (!rowsel_q[KMS_OFF_BIT])
    begin
      if (rowsel_q[KMS_ALL_BIT] || rowsel_q[4:0] >= 5'(ROWS))
      begin
        act_d = '1;
        if (rowsel_q[KMS_ALL_BIT])
          lvl_d = {ROWS{rowsel_q[KMS_INV_BIT]}};
        else
          lvl_d = {ROWS{~rowsel_q[KMS_INV_BIT]}};
      end
      else
      begin
        act_d[rowsel_q[4:0]] = 1'b1;
        lvl_d[rowsel_q[4:0]] = rowsel_q[KMS_INV_BIT];
      end
    end
  end

  // predrive: a row leaving its active state is pushed high first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      act_q <= '0;
      st_q <= KMS_IDLE;
      pre_cnt_q <= '0;
      row_drive_outputs <= '1;
      row_drive_oe_n <= '1;
    end
    else
    begin
      unique case (st_q)
        // a finished predrive releases like idle, and may start another
        KMS_IDLE, KMS_HOLD:
        begin
          act_q <= act_d;
          st_q <= KMS_IDLE;
          row_drive_outputs <= lvl_d;
          row_drive_oe_n <= ~act_d;
          if (pre_en_q && (act_q & ~act_d) != '0)
          begin
            row_drive_outputs <= lvl_d | (act_q & ~act_d);
            row_drive_oe_n <= ~(act_d | act_q);
            pre_cnt_q <= 8'(KMS_PRE_CYC - 1);
            st_q <= KMS_PRE;
          end
        end
        // act_q is held so a row dropped meanwhile is still predriven
        KMS_PRE:
        begin
          if (pre_cnt_q == '0)
            st_q <= KMS_HOLD;
          else
            pre_cnt_q <= pre_cnt_q - 8'd1;
        end
      endcase
    end
  end

  // write decode; an unmapped or misaligned offset is answered with an error
  always_comb
  begin
    wr_ok = 1'b0;
    unique case (aw_q)
      KMS_OFS_ROWSEL, KMS_OFS_COLIN, KMS_OFS_STS: wr_ok = 1'b1;
      KMS_OFS_IEN, KMS_OFS_EXT, KMS_OFS_PWR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // axi4-lite write channel; address and data accepted in any order
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= KMS_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? KMS_OKAY : KMS_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // control registers; only byte lane 0 carries bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rowsel_q <= KMS_ROWSEL_RST;
      pre_en_q <= 1'b0;
      ien_q <= '0;
    end
    else if (wr_go && ws_q[0])
    begin
      if (aw_q == KMS_OFS_ROWSEL)
        rowsel_q <= w_q[7:0];
      if (aw_q == KMS_OFS_IEN)
        ien_q <= w_q[COLS-1:0];
      if (aw_q == KMS_OFS_EXT)
        pre_en_q <= w_q[KMS_PRE_BIT];
    end
  end

  // sticky column status: write one clears, a new edge wins over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sts_q <= '0;
    else if (wr_go && ws_q[0] && aw_q == KMS_OFS_STS)
      sts_q <= (sts_q & ~w_q[COLS-1:0]) | fall;
    else
      sts_q <= sts_q | fall;
  end

  // interrupts and sleep hold-off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scan_runtime_irq <= 1'b0;
      scan_wake_irq <= 1'b0;
      scan_sleep_block <= 1'b0;
    end
    else
    begin
      scan_runtime_irq <= |(sts_q & ien_q);
      if (!stop_s2_q)
        scan_wake_irq <= 1'b0;
      else if (|(fall & ien_q))
        scan_wake_irq <= 1'b1;
      // active only while a row is driven or predrive runs
      // a row entering predrive already counts in its first driven cycle
      scan_sleep_block <= (|act_d) || st_q != KMS_IDLE ||
                          (pre_en_q && (act_q & ~act_d) != '0);
    end
  end

  // axi4-lite read channel
  always_comb
  begin
    rd_d = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      KMS_OFS_ROWSEL: rd_d[7:0] = rowsel_q;
      KMS_OFS_COLIN: rd_d[COLS-1:0] = col_s2_q;
      KMS_OFS_STS: rd_d[COLS-1:0] = sts_q;
      KMS_OFS_IEN: rd_d[COLS-1:0] = ien_q;
      KMS_OFS_EXT: rd_d[KMS_PRE_BIT] = pre_en_q;
      KMS_OFS_PWR:
      begin
        rd_d[KMS_ACT_BIT] = scan_sleep_block;
        rd_d[KMS_BUSSTOP_BIT] = stop_s2_q;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= KMS_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? KMS_OKAY : KMS_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire
